// file: core/dpim_an_mem.v
`timescale 1ns/1ps
// small word store for the analog output data, read data registered
module dpim_an_mem (
    input wire hclk,
    input wire we,
    input wire [2:0] waddr,
    input wire [7:0] wdata,
    input wire [2:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:7];

    // write port and registered read port
    always @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// file: core/dpim_consts.vh
`ifndef DPIM_CONSTS_VH
`define DPIM_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DPIM_OFF_TH_IN      12'h000
`define DPIM_OFF_TH_OUT     12'h004
`define DPIM_OFF_DI16_IN    12'h008
`define DPIM_OFF_DO1_OUT    12'h00c
`define DPIM_OFF_DO1_IN     12'h010
`define DPIM_OFF_DO2_OUT    12'h014
`define DPIM_OFF_DODIAG_IN  12'h018
`define DPIM_OFF_AN_OUT     12'h01c
`define DPIM_OFF_AN_BYTES   12'h020
`define DPIM_OFF_PACK_OUT   12'h024
`define DPIM_OFF_IRQ_STAT   12'h028
`define DPIM_OFF_IRQ_MASK   12'h02c

// ----------------------------------------
// field positions, widths and store size
// ----------------------------------------
`define DPIM_BYTE0_LSB      0
`define DPIM_BYTE1_LSB      8
`define DPIM_DO1_BIT        0
`define DPIM_DO2_WIDTH      2
`define DPIM_DODIAG_WIDTH   3
`define DPIM_AN_DEPTH       8
`define DPIM_AN_AW          3
`define DPIM_IRQ_WIDTH      4
`define DPIM_IRQ_TH_FAULT   0
`define DPIM_IRQ_DI16_CHG   1
`define DPIM_IRQ_MANUAL     2
`define DPIM_IRQ_DO_DIAG    3

// ----------------------------------------
// reset values
// ----------------------------------------
`define DPIM_RST_SHUTOFF    8'h00
`define DPIM_RST_DO1        1'b0
`define DPIM_RST_DO2        2'h0
`define DPIM_RST_AN_BYTES   4'h0
`define DPIM_RST_MASK       4'h0

`endif

// file: core/dpim_edge.v
`timescale 1ns/1ps
// per-bit change detector: one-cycle pulse where a bit differs from last cycle
module dpim_edge #(
    parameter W = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire [W-1:0] din,
    output wire [W-1:0] changed
);
    reg [W-1:0] last_q;
    genvar i;

    // remember previous value
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_q <= {W{1'b0}};
        end else begin
            last_q <= din;
        end
    end

    // compare each bit
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign changed[i] = din[i] ^ last_q[i];
        end
    endgenerate
endmodule

// file: core/dpim_top.v
// What this block does
// - thermistor module exchanges two input bytes and two output bytes, eight channels
// - thermistor signal states in first input byte, channel n at bit n-1
// - per-channel wire fault flags in second input byte, channel n at bit n-1
// - second output byte bit per channel: 0 channel on, 1 channel off
// - sixteen-channel input word, channel n at bit n-1
// - output modules take one image bit per channel setting that output
// - output modules with diagnostics give one diagnostic input bit per channel
// - digital output bits packed into bytes after all analog output data
// - one-channel output: control bit 0, manual status at input bit 0
// - two-channel output: bits 0 and 1 control channels 1 and 2
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dpim_consts.vh"
module dpim_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [7:0] input_signal_state,
    input wire [7:0] wire_fault_flag,
    input wire [15:0] di16_in,
    input wire do1_manual,
    input wire [2:0] do_diag_in,
    output reg [7:0] channel_shutoff_bit,
    output reg do1_out,
    output reg [1:0] do2_out,
    output reg [7:0] pack_byte,
    output reg pack_valid,
    output reg irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [7:0] shutoff_q;
    reg do1_q;
    reg [1:0] do2_q;
    reg [3:0] an_bytes_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg wr_pend_q;
    reg rd_pend_q;
    reg [11:0] addr_q;
    reg [3:0] pack_idx_q;
    reg pack_run_q;
    wire [15:0] di16_chg;
    wire [7:0] fault_chg;
    wire [7:0] an_rdata;
    wire [3:0] irq_evt;
    wire [31:0] rd_word;
    wire take;
    wire an_we;
    reg [31:0] rd_mux;

    assign take = hsel & hready & htrans[1];

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // true when the word address of a access matches an offset
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a[11:2] == off[11:2]);
        end
    endfunction

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    dpim_edge #(.W(16)) u_di16_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(di16_in),
        .changed(di16_chg)
    );

    dpim_edge #(.W(8)) u_fault_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(wire_fault_flag),
        .changed(fault_chg)
    );

    // rising fault, any input change, manual mode, output diagnostics
    assign irq_evt[`DPIM_IRQ_TH_FAULT] = |(fault_chg & wire_fault_flag);
    assign irq_evt[`DPIM_IRQ_DI16_CHG] = |di16_chg;
    assign irq_evt[`DPIM_IRQ_MANUAL] = do1_manual;
    assign irq_evt[`DPIM_IRQ_DO_DIAG] = |do_diag_in;

    // ----------------------------------------
    // analog output data store
    // ----------------------------------------
    assign an_we = wr_pend_q & hit(addr_q, `DPIM_OFF_AN_OUT);

    dpim_an_mem u_an_mem (
        .hclk(hclk),
        .we(an_we),
        .waddr(hwdata[10:8]),
        .wdata(hwdata[7:0]),
        .raddr(pack_idx_q[2:0]),
        .rdata(an_rdata)
    );

    // ----------------------------------------
    // bus address phase capture
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // ----------------------------------------
    // writable image bits
    // ----------------------------------------
    // only assigned bit positions are stored; others are dropped
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shutoff_q <= `DPIM_RST_SHUTOFF;
            do1_q <= `DPIM_RST_DO1;
            do2_q <= `DPIM_RST_DO2;
            an_bytes_q <= `DPIM_RST_AN_BYTES;
            irq_mask_q <= `DPIM_RST_MASK;
        end else if (wr_pend_q) begin
            if (hit(addr_q, `DPIM_OFF_TH_OUT)) begin
                shutoff_q <= hwdata[`DPIM_BYTE1_LSB +: 8];
            end
            if (hit(addr_q, `DPIM_OFF_DO1_OUT)) begin
                do1_q <= hwdata[`DPIM_DO1_BIT];
            end
            if (hit(addr_q, `DPIM_OFF_DO2_OUT)) begin
                do2_q <= hwdata[`DPIM_DO2_WIDTH-1:0];
            end
            if (hit(addr_q, `DPIM_OFF_AN_BYTES)) begin
                an_bytes_q <= (hwdata[3:0] > 4'h8) ? 4'h8 : hwdata[3:0];
            end
            if (hit(addr_q, `DPIM_OFF_IRQ_MASK)) begin
                irq_mask_q <= hwdata[`DPIM_IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------
    // interrupt status, set wins over clear
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= 4'h0;
        end else if (wr_pend_q && hit(addr_q, `DPIM_OFF_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~hwdata[`DPIM_IRQ_WIDTH-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // ----------------------------------------
    // packed output image stream
    // ----------------------------------------
    // a write to the pack register walks analog bytes, then the digital byte
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pack_idx_q <= 4'h0;
            pack_run_q <= 1'b0;
            pack_byte <= 8'h00;
            pack_valid <= 1'b0;
        end else begin
            pack_valid <= 1'b0;
            if (!pack_run_q) begin
                pack_idx_q <= 4'h0;
                if (wr_pend_q && hit(addr_q, `DPIM_OFF_PACK_OUT)) begin
                    pack_run_q <= 1'b1;
                end
            end else begin
                // one cycle to read the store, then emit
                pack_idx_q <= pack_idx_q + 4'h1;
                if (pack_idx_q != 4'h0 && pack_idx_q <= an_bytes_q) begin
                    pack_byte <= an_rdata;
                    pack_valid <= 1'b1;
                end
                if (pack_idx_q == an_bytes_q + 4'h1 || (pack_idx_q == 4'h0 && an_bytes_q == 4'h0)) begin
                    pack_byte <= {5'h00, do2_q, do1_q};
                    pack_valid <= 1'b1;
                    pack_run_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // read data mux
    // ----------------------------------------
    always @* begin
        rd_mux = 32'h00000000;
        if (hit(addr_q, `DPIM_OFF_TH_IN)) begin
            rd_mux[`DPIM_BYTE0_LSB +: 8] = input_signal_state;
            rd_mux[`DPIM_BYTE1_LSB +: 8] = wire_fault_flag;
        end
        if (hit(addr_q, `DPIM_OFF_TH_OUT)) begin
            rd_mux[`DPIM_BYTE1_LSB +: 8] = shutoff_q;
        end
        if (hit(addr_q, `DPIM_OFF_DI16_IN)) begin
            rd_mux[15:0] = di16_in;
        end
        if (hit(addr_q, `DPIM_OFF_DO1_OUT)) begin
            rd_mux[`DPIM_DO1_BIT] = do1_q;
        end
        if (hit(addr_q, `DPIM_OFF_DO1_IN)) begin
            rd_mux[0] = do1_manual;
        end
        if (hit(addr_q, `DPIM_OFF_DO2_OUT)) begin
            rd_mux[1:0] = do2_q;
        end
        if (hit(addr_q, `DPIM_OFF_DODIAG_IN)) begin
            rd_mux[`DPIM_DODIAG_WIDTH-1:0] = do_diag_in;
        end
        if (hit(addr_q, `DPIM_OFF_AN_BYTES)) begin
            rd_mux[3:0] = an_bytes_q;
        end
        if (hit(addr_q, `DPIM_OFF_PACK_OUT)) begin
            rd_mux[0] = pack_run_q;
        end
        if (hit(addr_q, `DPIM_OFF_IRQ_STAT)) begin
            rd_mux[3:0] = irq_stat_q;
        end
        if (hit(addr_q, `DPIM_OFF_IRQ_MASK)) begin
            rd_mux[3:0] = irq_mask_q;
        end
    end
    assign rd_word = rd_mux;

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // read data registered: valid one cycle after the data phase starts
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            channel_shutoff_bit <= `DPIM_RST_SHUTOFF;
            do1_out <= `DPIM_RST_DO1;
            do2_out <= `DPIM_RST_DO2;
            irq <= 1'b0;
        end else begin
            hreadyout <= ~(take & ~hwrite);
            hresp <= 1'b0;
            if (rd_pend_q) begin
                hrdata <= rd_word;
            end
            channel_shutoff_bit <= shutoff_q;
            do1_out <= do1_q;
            do2_out <= do2_q;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

// file: tb/dpim_field.sv
`timescale 1ns/1ps
// field channels seen by the block, all taken from one pattern
module dpim_field (
    input wire [15:0] pat,
    output wire [7:0] input_signal_state,
    output wire [7:0] wire_fault_flag,
    output wire [15:0] di16_in,
    output wire do1_manual,
    output wire [2:0] do_diag_in
);
    // channel levels
    assign input_signal_state = pat[7:0];
    assign wire_fault_flag = pat[15:8];
    assign di16_in = {pat[7:0], pat[15:8]};
    assign do1_manual = pat[0];
    assign do_diag_in = pat[10:8];
endmodule

// file: tb/dpim_top_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module dpim_mon (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [7:0] input_signal_state,
    input wire [7:0] wire_fault_flag,
    input wire [15:0] di16_in,
    input wire do1_manual,
    input wire [2:0] do_diag_in,
    input wire [7:0] channel_shutoff_bit,
    input wire do1_out,
    input wire [1:0] do2_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans[1];
    wire rd = take && !hwrite;
    reg w_q;
    reg [11:0] a_q;
    reg [31:0] d_q;
    // remember the write address phase and the data phase word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_q <= 1'b0;
            a_q <= 12'h000;
            d_q <= 32'h0;
        end else begin
            w_q <= take && hwrite;
            d_q <= hwdata;
            if (take)
                a_q <= haddr;
        end
    end
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bad response");
    AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write wait state");
    // outputs follow the stored value one cycle after the write lands
    AST_SHUTOFF: assert property (w_q && a_q == 12'h004 |=> ##1 channel_shutoff_bit == $past(d_q[15:8]))
        else $error("shutoff byte not taken from second byte");
    AST_DO1: assert property (w_q && a_q == 12'h00c |=> ##1 do1_out == $past(d_q[0]))
        else $error("single output not bit 0");
    AST_DO2: assert property (w_q && a_q == 12'h014 |=> ##1 do2_out == $past(d_q[1:0]))
        else $error("dual output not bits 1:0");
    AST_RD_TH: assert property (rd && haddr == 12'h000 |=> !hreadyout ##1
        hreadyout && hrdata == {16'h0000, wire_fault_flag, input_signal_state})
        else $error("thermistor word wrong");
    AST_RD_DI16: assert property (rd && haddr == 12'h008 |-> ##2 hrdata == {16'h0000, di16_in})
        else $error("input word wrong");
    AST_RD_MAN: assert property (rd && haddr == 12'h010 |-> ##2 hrdata == {31'h0, do1_manual})
        else $error("manual status wrong");
    AST_RD_DIAG: assert property (rd && haddr == 12'h018 |-> ##2 hrdata == {29'h0, do_diag_in})
        else $error("diagnostic bits wrong");
    AST_RD_HOLE: assert property (rd && haddr >= 12'h030 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg hclk, hresetn, hsel, hwrite;
    reg [11:0] haddr;
    reg [1:0] htrans;
    reg [31:0] hwdata, rd;
    reg [15:0] pat;
    reg [23:0] acc;
    wire [31:0] hrdata;
    wire hreadyout, hresp, do1_out, pack_valid, irq, do1_manual;
    wire [7:0] input_signal_state, wire_fault_flag, channel_shutoff_bit, pack_byte;
    wire [15:0] di16_in;
    wire [2:0] do_diag_in;
    wire [1:0] do2_out;
    integer err_count, cmp_count, i, k;
    integer cyc = 0;
    dpim_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .input_signal_state(input_signal_state),
        .wire_fault_flag(wire_fault_flag), .di16_in(di16_in), .do1_manual(do1_manual),
        .do_diag_in(do_diag_in), .channel_shutoff_bit(channel_shutoff_bit), .do1_out(do1_out),
        .do2_out(do2_out), .pack_byte(pack_byte), .pack_valid(pack_valid), .irq(irq));
    dpim_field u_field (.pat(pat), .input_signal_state(input_signal_state),
        .wire_fault_flag(wire_fault_flag), .di16_in(di16_in), .do1_manual(do1_manual),
        .do_diag_in(do_diag_in));
    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            give_verdict;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("mismatches=%0d compares=%0d", err_count, cmp_count);
            if (err_count == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task wait_rdy;
        begin
            @(posedge hclk);
            while (hreadyout !== 1'b1)
                @(posedge hclk);
        end
    endtask
    // one single-word transfer; read data lands in rd
    task bus(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy;
            rd = hrdata;
            // written outputs follow one edge after the write lands
            if (w)
                @(posedge hclk);
            #1;
        end
    endtask
    task set_pat(input [15:0] p);
        begin
            @(posedge hclk);
            pat <= p;
        end
    endtask
    task wait_irq(input v);
        begin
            for (i = 0; i < 10 && irq !== v; i = i + 1)
                @(posedge hclk);
            #1;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_therm;
        begin
            set_pat(16'h3ca5);
            bus(0, 12'h000, 0); chk(rd, 32'h00003ca5);
            bus(1, 12'h004, 32'h0000a500); chk(channel_shutoff_bit, 8'ha5);
            bus(0, 12'h004, 0); chk(rd, 32'h0000a500);
            bus(1, 12'h004, 32'h00000000); chk(channel_shutoff_bit, 8'h00);
        end
    endtask
    task t_outs;
        begin
            bus(1, 12'h00c, 32'hffffffff); chk(do1_out, 1'b1);
            bus(0, 12'h00c, 0); chk(rd, 32'h1);
            bus(1, 12'h014, 32'h000000fe); chk(do2_out, 2'h2);
            bus(0, 12'h010, 0); chk(rd, 32'h1);
            bus(0, 12'h018, 0); chk(rd, 32'h4);
            bus(0, 12'h014, 0); chk(rd, 32'h2);
            bus(0, 12'h008, 0); chk(rd, 32'h0000a53c);
        end
    endtask
    task t_holes;
        begin
            bus(1, 12'h040, 32'hffffffff);
            bus(0, 12'h040, 0); chk(rd, 32'h0);
            chk({channel_shutoff_bit, do2_out, do1_out}, 11'h005);
        end
    endtask
    task t_irq;
        begin
            bus(1, 12'h028, 32'hf);
            bus(1, 12'h02c, 32'h2);
            wait_irq(1'b1); chk(irq, 1'b0);
            set_pat(16'h3c5a);
            wait_irq(1'b1); chk(irq, 1'b1);
            bus(0, 12'h028, 0); chk(rd & 32'h2, 32'h2);
            bus(1, 12'h028, 32'h2);
            wait_irq(1'b0); chk(irq, 1'b0);
            bus(1, 12'h02c, 32'h0);
            set_pat(16'h3ca5);
            wait_irq(1'b1); chk(irq, 1'b0);
            bus(0, 12'h028, 0); chk(rd & 32'h2, 32'h2);
        end
    endtask
    // start a stream of n analog bytes and gather what comes out
    task t_pack(input [31:0] n, input [23:0] e, input [31:0] m);
        begin
            bus(1, 12'h020, n);
            bus(1, 12'h024, 32'h1);
            acc = 24'h0;
            k = 0;
            for (i = 0; i < 40; i = i + 1) begin
                @(posedge hclk);
                if (pack_valid === 1'b1) begin
                    acc = {acc[15:0], pack_byte};
                    k = k + 1;
                end
            end
            chk(acc, e);
            chk(k, m);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        err_count = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwdata = 32'h0;
        pat = 16'h0000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk({channel_shutoff_bit, do2_out, do1_out, irq}, 12'h000);
        t_therm;
        t_outs;
        t_holes;
        t_irq;
        bus(1, 12'h01c, 32'h0000003c);
        bus(1, 12'h01c, 32'h000001c3);
        t_pack(32'h2, 24'h3cc305, 32'h3);
        t_pack(32'h0, 24'h000005, 32'h1);
        give_verdict;
    end
endmodule
bind dpim_top dpim_mon u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .input_signal_state, .wire_fault_flag, .di16_in, .do1_manual,
    .do_diag_in, .channel_shutoff_bit, .do1_out, .do2_out);
